// File: inc/wdwk_pkg.sv
// Package: constants, types and register map of the watchdog wake block
//------------------------------------------------------------------------
// Function
// - Watchdog counts sub-clock, power-of-two time-out
// - Three-bit period field selects divide ratio
// - Key 10101B disables, 01010B enables watchdog
// - Other key values reset device after 2-3 ticks
// - Key reset sets flag; only write zero clears
// - Control register powers up enabled, period 011
// - Overflow while running: device reset, set timeout flag
// - Overflow asleep: timeout flag, reset PC and SP only
// - Counter cleared by key reset, clear, halt
// - Power-down flag: set by halt, clear instruction clears
// - Overflow while asleep wakes and starts watchdog reset
// - Enabled port A falling edge wakes, resumes after halt
// - Disabled or stack-full interrupt wake resumes after halt
// - Enabled interrupt with free stack wakes into vectoring
// - Request pending at halt cannot wake device
// - Sleep time-out leaves timeout and power-down flags set
//------------------------------------------------------------------------
package wdwk_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned LOW_FREQ_INTERNAL_OSC_PERIOD_NS = 31250;
  localparam int unsigned SUB_DIV        = LOW_FREQ_INTERNAL_OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  KEY_RST_TICKS  = 2'h3;
  localparam int unsigned CNT_W          = 18;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  ADDR_WDOG_CTRL  = 4'h0;
  localparam logic [3:0]  ADDR_SYS_FLAGS  = 4'h1;
  localparam logic [3:0]  ADDR_PWR_STATUS = 4'h2;
  localparam logic [3:0]  ADDR_PA_WAKE    = 4'h3;
  localparam logic [3:0]  ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h5;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned KEY_LSB        = 3;
  localparam int unsigned KEY_W          = 5;
  localparam int unsigned PERIOD_W       = 3;
  localparam logic [4:0]  KEY_DISABLE    = 5'h15;
  localparam logic [4:0]  KEY_ENABLE     = 5'h0a;
  localparam logic [7:0]  WDOG_CTRL_RST  = 8'h53;
  localparam int unsigned SYS_KEY_RST    = 0;
  localparam int unsigned SYS_CLK_KEEP   = 7;
  localparam int unsigned PWR_PDF        = 0;
  localparam int unsigned PWR_TO         = 1;
  localparam int unsigned PWR_ASLEEP     = 2;
  localparam int unsigned IRQ_EVT_W      = 3;

  // Time-out exponent for each period code
  localparam logic [4:0] WDT_EXP [8] = '{5'h08, 5'h0a, 5'h0c, 5'h0e,
                                         5'h0f, 5'h10, 5'h11, 5'h12};

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_RUN   = 2'b01,
    PWR_SLEEP = 2'b10
  } wdwk_pwr_type;

  typedef struct packed {
    logic wake;
    logic key_rst;
    logic tmo;
  } wdwk_evt_type;

endpackage

// File: logic/wdwk_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module wdwk_sync #(
  parameter int unsigned W       = 8,
  parameter logic        RST_VAL = 1'b1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= {W{RST_VAL}};
      q_o    <= {W{RST_VAL}};
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// File: logic/wdwk_tick.sv
// Divider giving the low-speed sub-clock as a one-cycle enable pulse
`timescale 1ns/1ps
module wdwk_tick #(
  parameter int unsigned DIV = 3125
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  localparam int unsigned CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_q == LAST);
    end
  end
endmodule

// File: logic/wdwk_top.sv
// Watchdog timer with key control, power-down flags and wake-up logic
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
module wdwk_top import wdwk_pkg::*; #(
  parameter int unsigned PA_W  = 8,
  parameter int unsigned IRQ_N = 4,
  parameter int unsigned DIV   = SUB_DIV
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic              watchdog_clear_instruction_i,
  input  wire logic              halt_i,
  input  wire logic [PA_W-1:0]   pa_pin_i,
  input  wire logic [IRQ_N-1:0]  irq_req_i,
  input  wire logic [IRQ_N-1:0]  irq_en_i,
  input  wire logic              stack_full_i,
  output logic                   dev_reset_o,
  output logic                   pc_sp_reset_o,
  output logic                   wake_o,
  output logic                   resume_next_o,
  output logic                   vector_o,
  output logic      [IRQ_N-1:0]  vector_irq_o,
  output logic                   asleep_o,
  output logic                   idle_sysclk_keep_o,
  output logic                   irq_o
);

  // ----------------------------------------------------------------------
  // Reset release and sub-clock
  // ----------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  logic sub_tick;

  wdwk_tick #(.DIV(DIV)) u_tick (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .tick_o    (sub_tick)
  );

  // Pins idle high, so reset to one avoids a false edge at start-up
  logic [PA_W-1:0] pa_sync;

  wdwk_sync #(.W(PA_W), .RST_VAL(1'b1)) u_pa_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .d_i       (pa_pin_i),
    .q_o       (pa_sync)
  );

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic key_legal(input logic [KEY_W-1:0] k);
    return (k == KEY_ENABLE) || (k == KEY_DISABLE);
  endfunction

  function automatic logic [CNT_W-1:0] period_last(
    input logic [PERIOD_W-1:0] sel);
    logic [CNT_W:0] one;
    one = (CNT_W+1)'(1);
    return CNT_W'((one << WDT_EXP[sel]) - 1'b1);
  endfunction

  // ----------------------------------------------------------------------
  // Register strobes
  // ----------------------------------------------------------------------
  logic wr_ctrl;
  logic wr_sys;
  logic wr_pa;
  logic wr_mask;
  logic rd_irq;

  assign wr_ctrl = reg_we_i && (reg_addr_i == ADDR_WDOG_CTRL);
  assign wr_sys  = reg_we_i && (reg_addr_i == ADDR_SYS_FLAGS);
  assign wr_pa   = reg_we_i && (reg_addr_i == ADDR_PA_WAKE);
  assign wr_mask = reg_we_i && (reg_addr_i == ADDR_IRQ_MASK);
  assign rd_irq  = reg_re_i && (reg_addr_i == ADDR_IRQ_STATUS);

  // ----------------------------------------------------------------------
  // Watchdog control and key check
  // ----------------------------------------------------------------------
  logic [7:0]          wdog_ctrl_q;
  logic [KEY_W-1:0]    key;
  logic [PERIOD_W-1:0] period;
  logic                wdt_en;
  logic                bad_key_wr;
  logic                key_pend_q;
  logic [1:0]          key_tick_q;
  logic                key_fire;

  assign key        = wdog_ctrl_q[KEY_LSB +: KEY_W];
  assign period     = wdog_ctrl_q[PERIOD_W-1:0];
  assign wdt_en     = (key == KEY_ENABLE);
  assign bad_key_wr = wr_ctrl && !key_legal(reg_wdata_i[KEY_LSB +: KEY_W]);
  // Three sub ticks from any phase gives 2 to 3 full periods
  assign key_fire   = key_pend_q && sub_tick &&
                      (key_tick_q == KEY_RST_TICKS - 2'h1);

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      wdog_ctrl_q <= WDOG_CTRL_RST;
    end else if (key_fire) begin
      wdog_ctrl_q <= WDOG_CTRL_RST;
    end else if (wr_ctrl) begin
      wdog_ctrl_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      key_pend_q <= 1'b0;
      key_tick_q <= 2'h0;
    end else if (key_fire) begin
      key_pend_q <= 1'b0;
      key_tick_q <= 2'h0;
    end else if (bad_key_wr && !key_pend_q) begin
      key_pend_q <= 1'b1;
      key_tick_q <= 2'h0;
    end else if (key_pend_q && sub_tick) begin
      key_tick_q <= key_tick_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------------
  wdwk_pwr_type     pwr_q;
  logic             asleep;
  logic             halt_go;
  logic [CNT_W-1:0] cnt_q;
  logic             wdt_tmo;

  assign asleep  = (pwr_q == PWR_SLEEP);
  assign halt_go = halt_i && !asleep;
  // Compare with >= so a period shortened mid-count still expires
  assign wdt_tmo = wdt_en && sub_tick &&
                   (cnt_q >= period_last(period));

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (key_fire || watchdog_clear_instruction_i || halt_go || wdt_tmo) begin
      cnt_q <= '0;
    end else if (wdt_en && sub_tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Power state and wake sources
  // ----------------------------------------------------------------------
  logic [PA_W-1:0]  pa_prev_q;
  logic [PA_W-1:0]  pa_wake_en_q;
  logic             pa_fall;
  logic [IRQ_N-1:0] blocked_q;
  logic [IRQ_N-1:0] irq_new;
  logic [IRQ_N-1:0] irq_serv;
  logic             take_vec;
  logic             wake_now;

  assign pa_fall  = |(pa_prev_q & ~pa_sync & pa_wake_en_q);
  assign irq_new  = irq_req_i & ~blocked_q;
  assign irq_serv = irq_new & irq_en_i;
  assign take_vec = (|irq_serv) && !stack_full_i;
  assign wake_now = asleep && (wdt_tmo || pa_fall || (|irq_new));

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pa_prev_q <= '1;
    end else begin
      pa_prev_q <= pa_sync;
    end
  end

  // A request that drops while asleep may wake the device when it returns
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      blocked_q <= '0;
    end else if (halt_go) begin
      blocked_q <= irq_req_i;
    end else begin
      blocked_q <= blocked_q & irq_req_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= PWR_RUN;
    end else begin
      case (pwr_q)
        PWR_RUN: begin
          if (halt_go) begin
            pwr_q <= PWR_SLEEP;
          end
        end
        PWR_SLEEP: begin
          if (wake_now) begin
            pwr_q <= PWR_RUN;
          end
        end
        default: begin
          pwr_q <= PWR_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Reset and wake pulses
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      dev_reset_o   <= 1'b0;
      pc_sp_reset_o <= 1'b0;
      wake_o        <= 1'b0;
      resume_next_o <= 1'b0;
      vector_o      <= 1'b0;
      vector_irq_o  <= '0;
    end else begin
      dev_reset_o   <= key_fire || (wdt_tmo && !asleep);
      pc_sp_reset_o <= wdt_tmo && asleep;
      wake_o        <= wake_now;
      resume_next_o <= wake_now && !wdt_tmo &&
                       (pa_fall || !take_vec);
      vector_o      <= wake_now && !wdt_tmo &&
                       !pa_fall && take_vec;
      vector_irq_o  <= (wake_now && !wdt_tmo && !pa_fall && take_vec) ?
                       irq_serv : '0;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  logic pdf_q;
  logic to_q;
  logic key_rst_flag_q;
  logic clk_keep_q;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pdf_q <= 1'b0;
    end else if (halt_go) begin
      pdf_q <= 1'b1;
    end else if (watchdog_clear_instruction_i) begin
      pdf_q <= 1'b0;
    end
  end

  // Time-out keeps the power-down flag, so a sleep time-out shows both
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      to_q <= 1'b0;
    end else if (wdt_tmo) begin
      to_q <= 1'b1;
    end else if (halt_go) begin
      to_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      key_rst_flag_q <= 1'b0;
      clk_keep_q     <= 1'b0;
    end else begin
      if (key_fire) begin
        key_rst_flag_q <= 1'b1;
      end else if (wr_sys && !reg_wdata_i[SYS_KEY_RST]) begin
        key_rst_flag_q <= 1'b0;
      end
      if (wr_sys) begin
        clk_keep_q <= reg_wdata_i[SYS_CLK_KEEP];
      end
    end
  end

  assign idle_sysclk_keep_o = clk_keep_q;
  assign asleep_o           = asleep;

  // ----------------------------------------------------------------------
  // Interrupt status, mask and wake enables
  // ----------------------------------------------------------------------
  wdwk_evt_type         evt;
  logic [IRQ_EVT_W-1:0] irq_st_q;
  logic [IRQ_EVT_W-1:0] irq_mask_q;

  assign evt.wake    = wake_now;
  assign evt.key_rst = key_fire;
  assign evt.tmo     = wdt_tmo;

  // Set wins over the clear-on-read
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (rd_irq ? '0 : irq_st_q) | evt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q   <= '0;
      pa_wake_en_q <= '0;
    end else begin
      if (wr_mask) begin
        irq_mask_q <= reg_wdata_i[IRQ_EVT_W-1:0];
      end
      if (wr_pa) begin
        pa_wake_en_q <= reg_wdata_i[PA_W-1:0];
      end
    end
  end

  assign irq_o = |(irq_st_q & irq_mask_q);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        ADDR_WDOG_CTRL:  reg_rdata_o <= wdog_ctrl_q;
        ADDR_SYS_FLAGS:  reg_rdata_o <= {clk_keep_q, 6'h00, key_rst_flag_q};
        ADDR_PWR_STATUS: reg_rdata_o <= {5'h00, asleep, to_q, pdf_q};
        ADDR_PA_WAKE:    reg_rdata_o <= 8'(pa_wake_en_q);
        ADDR_IRQ_STATUS: reg_rdata_o <= 8'(irq_st_q);
        ADDR_IRQ_MASK:   reg_rdata_o <= 8'(irq_mask_q);
        default:         reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  // A time-out in the halt cycle itself keeps its flag: the set wins
  halt_sets_pdf_a: assert property (
    halt_go |=> pdf_q && asleep_o && (to_q == $past(wdt_tmo)))
    else $error("halt did not set power-down flag");

  clr_drops_pdf_a: assert property (
    watchdog_clear_instruction_i && !halt_go |=> !pdf_q && (cnt_q == '0))
    else $error("clear instruction did not clear flag or counter");

  run_tmo_reset_a: assert property (
    wdt_tmo && !asleep |=> dev_reset_o && to_q && !pc_sp_reset_o)
    else $error("running time-out did not reset device");

  sleep_tmo_wake_a: assert property (
    wdt_tmo && asleep |=> pc_sp_reset_o && !dev_reset_o && wake_o)
    else $error("sleep time-out did not wake with PC reset");

  sleep_tmo_flags_a: assert property (
    wdt_tmo && asleep |=> to_q && pdf_q)
    else $error("sleep time-out lost a flag");

  key_delay_a: assert property (
    bad_key_wr && !key_pend_q |=> key_pend_q && !dev_reset_o ##1
                                  !dev_reset_o)
    else $error("bad key reset came too early");

  key_flag_a: assert property (
    key_fire |=> dev_reset_o && key_rst_flag_q &&
                 (wdog_ctrl_q == WDOG_CTRL_RST))
    else $error("key reset did not set its flag");

  cnt_hold_a: assert property (
    !wdt_en && !key_fire && !watchdog_clear_instruction_i && !halt_go |=> $stable(cnt_q))
    else $error("counter moved while disabled");

  pa_wake_a: assert property (
    asleep && pa_fall && !wdt_tmo |=> wake_o && resume_next_o && !vector_o)
    else $error("port edge wake did not resume");

  blocked_irq_a: assert property (
    asleep && !pa_fall && !wdt_tmo && (irq_new == '0) |=> !wake_o)
    else $error("pending request woke the device");

endmodule

// File: test/wdwk_core.sv
// Processor core model issuing clear, halt and interrupt requests
`timescale 1ns/1ps
module wdwk_core #(
  parameter int unsigned IRQ_N = 4
) (
  input  wire logic             clk_sys_i,
  output logic                  watchdog_clear_instruction_o,
  output logic                  halt_o,
  output logic      [IRQ_N-1:0] irq_req_o,
  output logic      [IRQ_N-1:0] irq_en_o,
  output logic                  stack_full_o
);
  initial begin
    watchdog_clear_instruction_o    = 1'b0;
    halt_o       = 1'b0;
    irq_req_o    = '0;
    irq_en_o     = '0;
    stack_full_o = 1'b0;
  end

  // One-cycle instruction pulse: clear or halt, the two instructions that
  // clear the counter; no other instruction is modelled
  task automatic instr(input bit is_halt);
    @(posedge clk_sys_i);
    if (is_halt) begin
      halt_o <= 1'b1;
    end else begin
      watchdog_clear_instruction_o <= 1'b1;
    end
    @(posedge clk_sys_i);
    halt_o    <= 1'b0;
    watchdog_clear_instruction_o <= 1'b0;
  endtask

  // Requests are held here until the core drops them
  task automatic set_irq(input logic [IRQ_N-1:0] req,
                         input logic [IRQ_N-1:0] en,
                         input logic             full);
    @(posedge clk_sys_i);
    irq_req_o    <= req;
    irq_en_o     <= en;
    stack_full_o <= full;
  endtask
endmodule

// File: test/tb_top.sv
// Self-checking bench for the watchdog and wake-up block
`timescale 1ns/1ps
module tb_top;
  import wdwk_pkg::*;
  // Short sub-clock divider keeps the shortest time-out near a thousand cycles
  localparam int unsigned TDIV = 4;
  logic       clk_sys_i;
  logic       rstn_i;
  logic [3:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic       reg_we_i;
  logic       reg_re_i;
  logic [7:0] pa_pin_i;
  logic [7:0] reg_rdata_o;
  logic       clr, halt, sfull, dev_rst, pcsp, wake, resume, vect;
  logic       asleep, keep, irq_o;
  logic [3:0] irq_req, irq_en, vec_irq;
  wire  [3:0] ev = {vect, resume, pcsp, dev_rst};
  int         errors     = 0;
  int         num_checks = 0;

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  wdwk_core #(.IRQ_N(4)) core (
    .clk_sys_i(clk_sys_i), .watchdog_clear_instruction_o(clr), .halt_o(halt),
    .irq_req_o(irq_req), .irq_en_o(irq_en), .stack_full_o(sfull));

  wdwk_top #(.PA_W(8), .IRQ_N(4), .DIV(TDIV)) dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .watchdog_clear_instruction_i(clr),
    .halt_i(halt), .pa_pin_i(pa_pin_i), .irq_req_i(irq_req),
    .irq_en_i(irq_en), .stack_full_i(sfull), .dev_reset_o(dev_rst),
    .pc_sp_reset_o(pcsp), .wake_o(wake), .resume_next_o(resume),
    .vector_o(vect), .vector_irq_o(vec_irq), .asleep_o(asleep),
    .idle_sysclk_keep_o(keep), .irq_o(irq_o));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_we_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_we_i    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_re_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_re_i   <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask

  // No device or PC/SP reset, resume or vector pulse for lim cycles (wake_o is not watched)
  task automatic quiet(input int lim);
    logic [3:0] seen;
    seen = 4'h0;
    repeat (lim) begin
      @(posedge clk_sys_i);
      #1;
      seen = seen | ev;
    end
    chk({4'h0, seen}, 8'h00);
  endtask

  // Pulse i must show within lim cycles; returns in its cycle
  task automatic wait_ev(input int i, input int lim);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < lim && !hit; n++) begin
      @(posedge clk_sys_i);
      #1;
      hit = (ev[i] === 1'b1);
    end
    chk({7'h0, hit}, 8'h01);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    end_sim();
  end

  initial begin
    rstn_i      <= 1'b0;
    reg_addr_i  <= 4'h0;
    reg_wdata_i <= 8'h00;
    reg_we_i    <= 1'b0;
    reg_re_i    <= 1'b0;
    pa_pin_i    <= 8'hff;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd(ADDR_WDOG_CTRL, WDOG_CTRL_RST);
    rd(ADDR_SYS_FLAGS, 8'h00);
    rd(ADDR_PWR_STATUS, 8'h00);
    rd(4'hf, 8'h00);
    $display("test reset done");
    // Clears hold off the shortest period, then it must expire
    wr(ADDR_WDOG_CTRL, {KEY_ENABLE, 3'b000});
    core.instr(1'b0);
    repeat (3) begin
      quiet(900);
      core.instr(1'b0);
    end
    quiet(1000);
    wait_ev(0, 40);
    rd(ADDR_PWR_STATUS, 8'h02);
    // Code 001 must outlast the 2^8 span and expire near 2^10 ticks
    wr(ADDR_WDOG_CTRL, {KEY_ENABLE, 3'b001});
    core.instr(1'b0);
    quiet(4000);
    wait_ev(0, 200);
    chk({7'h0, irq_o}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h01);
    #1;
    chk({7'h0, irq_o}, 8'h01);
    rd(ADDR_IRQ_STATUS, 8'h01);
    rd(ADDR_IRQ_STATUS, 8'h00);
    chk({7'h0, irq_o}, 8'h00);
    $display("test run time-out done");
    wr(ADDR_WDOG_CTRL, {KEY_DISABLE, 3'b000});
    quiet(1200);
    wr(ADDR_WDOG_CTRL, 8'hf8);
    quiet(5);
    wait_ev(0, 15);
    rd(ADDR_SYS_FLAGS, 8'h01);
    rd(ADDR_WDOG_CTRL, WDOG_CTRL_RST);
    wr(ADDR_SYS_FLAGS, 8'h81);
    rd(ADDR_SYS_FLAGS, 8'h81);
    chk({7'h0, keep}, 8'h01);
    wr(ADDR_SYS_FLAGS, 8'h00);
    rd(ADDR_SYS_FLAGS, 8'h00);
    rd(ADDR_IRQ_STATUS, 8'h02);
    $display("test key done");
    // Time-out while asleep wakes with a PC and SP reset only
    wr(ADDR_WDOG_CTRL, {KEY_ENABLE, 3'b000});
    core.instr(1'b1);
    rd(ADDR_PWR_STATUS, 8'h05);
    chk({7'h0, asleep}, 8'h01);
    quiet(950);
    wait_ev(1, 100);
    chk({6'h0, wake, dev_rst}, 8'h02);
    rd(ADDR_PWR_STATUS, 8'h03);
    chk({7'h0, asleep}, 8'h00);
    core.instr(1'b0);
    rd(ADDR_PWR_STATUS, 8'h02);
    rd(ADDR_IRQ_STATUS, 8'h05);
    $display("test sleep time-out done");
    wr(ADDR_WDOG_CTRL, {KEY_DISABLE, 3'b011});
    wr(ADDR_PA_WAKE, 8'h01);
    core.instr(1'b1);
    @(posedge clk_sys_i);
    pa_pin_i <= 8'hfd;
    quiet(10);
    @(posedge clk_sys_i);
    pa_pin_i <= 8'hfc;
    wait_ev(2, 10);
    pa_pin_i <= 8'hff;
    $display("test port wake done");
    // A request already up at halt must not wake
    core.set_irq(4'h1, 4'hf, 1'b0);
    core.instr(1'b1);
    quiet(20);
    core.set_irq(4'h3, 4'hf, 1'b0);
    wait_ev(3, 5);
    chk({4'h0, vec_irq}, 8'h02);
    // Disabled request, then stack full: both resume after halt
    for (int k = 0; k < 2; k++) begin
      core.set_irq(4'h0, k ? 4'hf : 4'hb, k[0]);
      core.instr(1'b1);
      core.set_irq(4'h4, k ? 4'hf : 4'hb, k[0]);
      wait_ev(2, 5);
    end
    $display("test irq wake done");
    end_sim();
  end
endmodule
